// file: dv/adu_client_model.sv
`timescale 1ns/100ps
module adu_client_model (
    // Clock
    input wire logic ref_clk,
    // Request stream
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_seg_end,
    output logic [15:0] rx_dst_port,
    input wire logic rx_ready,
    // Response stream
    input wire logic tx_valid,
    input wire adu_pkg::byte_beat_t tx_beat,
    output logic tx_ready
);
    logic [24:0] q[$];
    adu_pkg::byte_beat_t got[$];

    initial
    begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_seg_end = 1'b0;
        rx_dst_port = 16'h0000;
        tx_ready = 1'b0;
    end

    // ----------------------------
    // Unit builder, split over two segments
    // ----------------------------
    task automatic send(input logic [15:0] tid, pid, port,
                        input logic [7:0] uid, input logic [7:0] b[$],
                        input logic pk);
        logic [7:0] h[$];
        logic [15:0] len;
        len = 16'(b.size() + 1);
        h = {tid[15:8], tid[7:0], pid[15:8], pid[7:0]};
        h.push_back(len[15:8]);
        h.push_back(len[7:0]);
        h.push_back(uid);
        foreach (b[i])
            h.push_back(b[i]);
        foreach (h[i])
            q.push_back({port, i == h.size() - 1 ? pk : i == 2, h[i]});
    endtask

    always @(posedge ref_clk)
    begin
        if (rx_valid && rx_ready)
            void'(q.pop_front());
        if (tx_valid && tx_ready)
            got.push_back(tx_beat);
        tx_ready <= $urandom % 3 != 0;
        if (rx_valid && !rx_ready)
            rx_valid <= 1'b1;
        else if (q.size() != 0 && $urandom % 4 != 0)
        begin
            rx_valid <= 1'b1;
            {rx_dst_port, rx_seg_end, rx_data} <= q[0];
        end
        else
        begin
            rx_valid <= 1'b0;
            rx_data <= ~rx_data;
        end
    end
endmodule

// file: dv/adu_framer_asserts.sv
`timescale 1ns/100ps
module adu_framer_checker (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Request side
    input wire logic pdu_valid,
    input wire adu_pkg::byte_beat_t pdu_beat,
    input wire logic pdu_ready,
    input wire adu_pkg::adu_hdr_t req_hdr,
    input wire logic req_done,
    input wire logic req_len_err,
    // Response side
    input wire logic rsp_start,
    input wire logic [15:0] rsp_pdu_len,
    input wire logic tx_valid,
    input wire adu_pkg::byte_beat_t tx_beat,
    input wire logic tx_ready
);
    // ----------------------------
    // Position within the response
    // ----------------------------
    logic [15:0] idx_reg;
    logic [15:0] rlen_reg;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            idx_reg <= 16'h0000;
            rlen_reg <= 16'h0000;
        end
        else
        begin
            if (rsp_start)
                rlen_reg <= rsp_pdu_len + 16'h0001;
            if (tx_valid && tx_ready)
                idx_reg <= tx_beat.last ? 16'h0000 : idx_reg + 16'h0001;
        end
    end

    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // ----------------------------
    // Properties
    // ----------------------------
    AST_PDU_HOLD: assert property (
        pdu_valid && !pdu_ready |=> pdu_valid && $stable(pdu_beat))
        else $error("pdu beat lost while stalled");
    AST_TX_HOLD: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_beat))
        else $error("tx beat lost while stalled");
    AST_DONE_PULSE: assert property (
        req_done |=> !req_done)
        else $error("done longer than one cycle");
    AST_DONE_PID: assert property (
        req_done |-> req_hdr.pid == adu_pkg::PROTO_ID)
        else $error("done for foreign protocol tag");
    AST_TX_TID: assert property (
        tx_valid && idx_reg < 16'h0002 |-> tx_beat.data ==
        (idx_reg[0] ? req_hdr.tid[7:0] : req_hdr.tid[15:8]))
        else $error("transaction tag not echoed");
    AST_TX_PID: assert property (
        tx_valid && (idx_reg == 16'h0002 || idx_reg == 16'h0003)
        |-> tx_beat.data == 8'h00)
        else $error("protocol tag not zero");
    AST_TX_LEN: assert property (
        tx_valid && (idx_reg == 16'h0004 || idx_reg == 16'h0005)
        |-> tx_beat.data == (idx_reg[0] ? rlen_reg[7:0] : rlen_reg[15:8]))
        else $error("response length wrong");
    AST_TX_UID: assert property (
        tx_valid && idx_reg == 16'h0006 |-> tx_beat.data == req_hdr.uid)
        else $error("unit tag not echoed");
    AST_TX_LAST: assert property (
        tx_valid |-> tx_beat.last == (idx_reg == rlen_reg + 16'h0005))
        else $error("response end misplaced");
    AST_LEN1_ERR: assert property (
        req_done && req_hdr.len == 16'h0001 |-> ##[0:1] req_len_err)
        else $error("short unit not flagged");
endmodule

// file: dv/adu_header_framer_tb.sv
`timescale 1ns/100ps
module adu_header_framer_tb;
    logic ref_clk, rst_n, rx_valid, rx_seg_end, rx_ready, pdu_valid;
    logic pdu_ready, req_write, req_done, req_len_err, req_pack_err;
    logic rsp_start, rsp_valid, rsp_ready, rsp_active, tx_valid, tx_ready;
    logic [7:0] rx_data, req_func, rsp_data, f;
    logic [15:0] rx_dst_port, rsp_pdu_len;
    adu_pkg::byte_beat_t pdu_beat, tx_beat;
    adu_pkg::adu_hdr_t req_hdr;
    adu_pkg::table_t req_table;
    int done_cnt, pack_cnt, bad_count, check_count, d0, want;
    logic [8:0] pdu_got[$];
    logic [7:0] codes[10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
                              8'h0f, 8'h10, 8'h16, 8'h17};

    adu_header_framer dut (.ref_clk, .rst_n, .rx_valid, .rx_data,
        .rx_seg_end, .rx_dst_port, .rx_ready, .pdu_valid, .pdu_beat,
        .pdu_ready, .req_hdr, .req_func, .req_table, .req_write, .req_done,
        .req_len_err, .req_pack_err, .rsp_start, .rsp_pdu_len, .rsp_valid,
        .rsp_data, .rsp_ready, .rsp_active, .tx_valid, .tx_beat, .tx_ready);
    adu_client_model cli (.ref_clk, .rx_valid, .rx_data, .rx_seg_end,
        .rx_dst_port, .rx_ready, .tx_valid, .tx_beat, .tx_ready);

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        pdu_ready <= $urandom % 4 != 0;
        if (pdu_valid && pdu_ready)
            pdu_got.push_back(pdu_beat);
        if (req_done)
            done_cnt++;
        if (req_pack_err)
            pack_cnt++;
    end

    // ----------------------------
    // Helpers
    // ----------------------------
    task automatic check(input logic [63:0] got, exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic await(input int c);
        for (int k = 0; k < 600; k++)
        begin
            @(negedge ref_clk);
            if (c == 0 ? rsp_ready && rsp_active : c == 2 ?
                cli.got.size() == want : cli.q.size() == 0 &&
                (c == 3 || done_cnt != d0 && pdu_got.size() == want))
                return;
        end
        bad_count++;
        $display("ERROR %0t: wait timed out", $time);
        finish_test();
    endtask

    function automatic adu_pkg::table_t tbl(input logic [7:0] c);
        if (c inside {8'h01, 8'h05, 8'h0f})
            return adu_pkg::TBL_COIL;
        if (c == 8'h02)
            return adu_pkg::TBL_DISCRETE;
        if (c == 8'h04)
            return adu_pkg::TBL_INPUT_WORD;
        return adu_pkg::TBL_HOLDING_WORD;
    endfunction

    function automatic int good_n(input logic [7:0] c);
        if (c == 8'h16)
            return 7;
        if (c == 8'h17)
            return 11 + $urandom % 4;
        if (c > 8'h06)
            return 7 + $urandom % 4;
        return 5;
    endfunction

    task automatic respond(input logic [15:0] tid, input logic [7:0] uid,
                           input int n);
        logic [7:0] e[$];
        logic [15:0] len;
        len = 16'(n + 1);
        e = {tid[15:8], tid[7:0], 8'h00, 8'h00, len[15:8], len[7:0], uid};
        for (int i = 0; i < n; i++)
            e.push_back(8'($urandom));
        cli.got = {};
        want = n + 7;
        @(posedge ref_clk);
        rsp_start <= 1'b1;
        rsp_pdu_len <= 16'(n);
        @(posedge ref_clk);
        rsp_start <= 1'b0;
        for (int i = 7; i < want; i++)
        begin
            rsp_valid <= 1'b1;
            rsp_data <= e[i];
            await(0);
            @(posedge ref_clk);
        end
        rsp_valid <= 1'b0;
        await(2);
        foreach (e[i])
            check({cli.got[i].last, cli.got[i].data},
                  {i == want - 1, e[i]});
    endtask

    task automatic req(input logic [7:0] fc, input int n,
                       input logic [15:0] pid, port, input logic pk, err);
        logic [7:0] b[$];
        logic [15:0] tid;
        logic [7:0] uid;
        int p0;
        tid = 16'($urandom);
        uid = 8'($urandom);
        for (int i = 0; i < n; i++)
            b.push_back(i == 0 ? fc : 8'($urandom));
        if (fc inside {8'h0f, 8'h10} && n > 5)
            b[5] = 8'(n - 6);
        if (fc == 8'h17 && n > 9)
            b[9] = 8'(n - 10);
        @(negedge ref_clk);
        d0 = done_cnt;
        p0 = pack_cnt;
        want = n;
        pdu_got = {};
        cli.send(tid, pid, port, uid, b, pk);
        if (pid !== adu_pkg::PROTO_ID || port !== adu_pkg::SERVER_PORT)
        begin
            await(3);
            repeat (12) @(posedge ref_clk);
            check(done_cnt, d0);
            check(pdu_got.size(), 0);
            return;
        end
        await(1);
        check(done_cnt - d0, 1);
        check(req_hdr, {tid, 16'h0000, 16'(n + 1), uid});
        check(pack_cnt - p0, !pk);
        check(req_len_err, err);
        if (n > 0)
        begin
            check(req_func, fc);
            check(req_table, tbl(fc));
            check(req_write, fc > 8'h04);
        end
        foreach (b[i])
            check(pdu_got[i], {b[i], i == n - 1});
        respond(tid, uid, $urandom % 6);
    endtask

    // ----------------------------
    // Main sequence
    // ----------------------------
    initial
    begin
        rst_n = 1'b0;
        pdu_ready = 1'b0;
        rsp_start = 1'b0;
        rsp_pdu_len = 16'h0000;
        rsp_valid = 1'b0;
        rsp_data = 8'h00;
        void'($urandom(32'h861ff1a6));
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        foreach (codes[i])
            req(codes[i], good_n(codes[i]), 16'h0000, adu_pkg::SERVER_PORT,
                1'b1, 1'b0);
        $display("test all codes finished");
        req(8'h03, 5, 16'h0001, adu_pkg::SERVER_PORT, 1'b1, 1'b0);
        req(8'h03, 5, 16'h0000, 16'h01f7, 1'b1, 1'b0);
        req(8'h04, 5, 16'h0000, adu_pkg::SERVER_PORT, 1'b1, 1'b0);
        $display("test dropped units finished");
        req(8'h03, 6, 16'h0000, adu_pkg::SERVER_PORT, 1'b1, 1'b1);
        req(8'h03, 0, 16'h0000, adu_pkg::SERVER_PORT, 1'b1, 1'b1);
        req(8'h10, 9, 16'h0000, adu_pkg::SERVER_PORT, 1'b0, 1'b0);
        $display("test faulty units finished");
        for (int i = 0; i < 8; i++)
        begin
            f = codes[$urandom % 10];
            req(f, good_n(f), 16'h0000, adu_pkg::SERVER_PORT, 1'b1, 1'b0);
        end
        $display("test random units finished");
        finish_test();
    end
endmodule

bind adu_header_framer adu_framer_checker chk (.ref_clk, .rst_n, .pdu_valid,
    .pdu_beat, .pdu_ready, .req_hdr, .req_done, .req_len_err, .rsp_start,
    .rsp_pdu_len, .tx_valid, .tx_beat, .tx_ready);

// file: shared/adu_pkg.sv
package adu_pkg;

    // ------------------------------------------------------------
    // Header layout
    // ------------------------------------------------------------
    localparam logic [2:0] HDR_BYTES = 3'h7;
    localparam logic [2:0] POS_TID_HI = 3'h0;
    localparam logic [2:0] POS_TID_LO = 3'h1;
    localparam logic [2:0] POS_PID_HI = 3'h2;
    localparam logic [2:0] POS_PID_LO = 3'h3;
    localparam logic [2:0] POS_LEN_HI = 3'h4;
    localparam logic [2:0] POS_LEN_LO = 3'h5;
    localparam logic [2:0] POS_UID = 3'h6;
    localparam logic [15:0] PROTO_ID = 16'h0000;
    localparam logic [15:0] SERVER_PORT = 16'h01f6;
    localparam logic [15:0] UID_BYTES = 16'h0001;

    // ------------------------------------------------------------
    // Function codes and their fixed sizes
    // ------------------------------------------------------------
    localparam logic [7:0] FC_RD_COILS = 8'h01;
    localparam logic [7:0] FC_RD_DISC = 8'h02;
    localparam logic [7:0] FC_RD_HOLD = 8'h03;
    localparam logic [7:0] FC_RD_INPUT = 8'h04;
    localparam logic [7:0] FC_WR_COIL = 8'h05;
    localparam logic [7:0] FC_WR_WORD = 8'h06;
    localparam logic [7:0] FC_WR_COILS = 8'h0f;
    localparam logic [7:0] FC_WR_WORDS = 8'h10;
    localparam logic [7:0] FC_MASK_WR = 8'h16;
    localparam logic [7:0] FC_RW_WORDS = 8'h17;
    localparam logic [15:0] PDU_LEN_SIMPLE = 16'h0005;
    localparam logic [15:0] PDU_LEN_MASK = 16'h0007;
    localparam logic [15:0] BC_POS_WRMULT = 16'h0005;
    localparam logic [15:0] BC_POS_RW = 16'h0009;
    localparam logic [15:0] PDU_FIXED_WRMULT = 16'h0006;
    localparam logic [15:0] PDU_FIXED_RW = 16'h000a;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        TBL_NONE = 3'h0,
        TBL_DISCRETE = 3'h1,
        TBL_COIL = 3'h2,
        TBL_INPUT_WORD = 3'h3,
        TBL_HOLDING_WORD = 3'h4
    } table_t;

    typedef enum logic [1:0] {
        RX_HDR = 2'h0,
        RX_BODY = 2'h1,
        RX_SKIP = 2'h3
    } rx_state_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'h0,
        TX_HDR = 2'h1,
        TX_BODY = 2'h3
    } tx_state_t;

    typedef struct packed {
        logic [15:0] tid;
        logic [15:0] pid;
        logic [15:0] len;
        logic [7:0] uid;
    } adu_hdr_t;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } byte_beat_t;

endpackage

// file: src/adu_header_framer.sv
`timescale 1ns/100ps
// Overview of operation
// - Seven-byte header: transaction, protocol, length, unit.
// - Response echoes request transaction tag.
// - Protocol tag zero; echoed unchanged.
// - Length counts unit byte plus PDU bytes.
// - Response length computed fresh, never copied.
// - Unit tag echoed exactly in response.
// - Multi-byte fields are most significant first.
// - Units travel over TCP to port 502.
// - Length field finds boundaries across segments.
// - Size check from function code or byte count.
// - Function code selects the server action.
// - Four tables: discretes, coils, input, holding words.
// - One unit per TCP segment only; a unit not ending its segment is accepted with req_pack_err.
module adu_header_framer (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Received byte stream
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_seg_end,
    input wire logic [15:0] rx_dst_port,
    output logic rx_ready,
    // Received PDU towards server logic
    output logic pdu_valid,
    output adu_pkg::byte_beat_t pdu_beat,
    input wire logic pdu_ready,
    // Decoded request
    output adu_pkg::adu_hdr_t req_hdr,
    output logic [7:0] req_func,
    output adu_pkg::table_t req_table,
    output logic req_write,
    output logic req_done,
    output logic req_len_err,
    output logic req_pack_err,
    // Response from server logic
    input wire logic rsp_start,
    input wire logic [15:0] rsp_pdu_len,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    output logic rsp_ready,
    output logic rsp_active,
    // Transmitted byte stream
    output logic tx_valid,
    output adu_pkg::byte_beat_t tx_beat,
    input wire logic tx_ready
);

    typedef struct packed {
        adu_pkg::rx_state_t rst;
        logic [2:0] ridx;
        adu_pkg::adu_hdr_t hdr;
        logic [15:0] rem, pos;
        logic [7:0] bc;
        logic drop;
        logic [7:0] func;
        adu_pkg::table_t tbl;
        logic wr, done, len_err, pack_err;
        adu_pkg::tx_state_t tst;
        logic [2:0] tidx;
        logic [15:0] tlen, trem;
    } frm_state_t;
    frm_state_t s_reg, s_next;
    logic rxb_valid, rxb_ready, txb_valid, txb_ready, rx_take, rsp_take;
    adu_pkg::byte_beat_t rxb_beat, txb_beat;
    logic [15:0] rsp_len_field;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic adu_pkg::table_t table_of(input logic [7:0] fc);
        case (fc)
            adu_pkg::FC_RD_DISC: table_of = adu_pkg::TBL_DISCRETE;
            adu_pkg::FC_RD_COILS, adu_pkg::FC_WR_COIL, adu_pkg::FC_WR_COILS:
                table_of = adu_pkg::TBL_COIL;
            adu_pkg::FC_RD_INPUT: table_of = adu_pkg::TBL_INPUT_WORD;
            adu_pkg::FC_RD_HOLD, adu_pkg::FC_WR_WORD, adu_pkg::FC_WR_WORDS,
            adu_pkg::FC_MASK_WR, adu_pkg::FC_RW_WORDS:
                table_of = adu_pkg::TBL_HOLDING_WORD;
            default: table_of = adu_pkg::TBL_NONE;
        endcase
    endfunction
    function automatic logic is_write(input logic [7:0] fc);
        is_write = (fc == adu_pkg::FC_WR_COIL) || (fc == adu_pkg::FC_WR_WORD)
            || (fc == adu_pkg::FC_WR_COILS) || (fc == adu_pkg::FC_WR_WORDS)
            || (fc == adu_pkg::FC_MASK_WR) || (fc == adu_pkg::FC_RW_WORDS);
    endfunction
    // Byte-count position inside the PDU, zero when the size is fixed
    function automatic logic [15:0] bc_pos(input logic [7:0] fc);
        case (fc)
            adu_pkg::FC_WR_COILS,
            adu_pkg::FC_WR_WORDS: bc_pos = adu_pkg::BC_POS_WRMULT;
            adu_pkg::FC_RW_WORDS: bc_pos = adu_pkg::BC_POS_RW;
            default: bc_pos = 16'h0000;
        endcase
    endfunction
    // Expected PDU size, zero when the code is not known
    function automatic logic [15:0] pdu_len(input logic [7:0] fc,
                                            input logic [7:0] bc);
        case (fc)
            adu_pkg::FC_RD_COILS, adu_pkg::FC_RD_DISC, adu_pkg::FC_RD_HOLD,
            adu_pkg::FC_RD_INPUT, adu_pkg::FC_WR_COIL, adu_pkg::FC_WR_WORD:
                pdu_len = adu_pkg::PDU_LEN_SIMPLE;
            adu_pkg::FC_MASK_WR: pdu_len = adu_pkg::PDU_LEN_MASK;
            adu_pkg::FC_WR_COILS, adu_pkg::FC_WR_WORDS:
                pdu_len = adu_pkg::PDU_FIXED_WRMULT + {8'h00, bc};
            adu_pkg::FC_RW_WORDS: pdu_len = adu_pkg::PDU_FIXED_RW
                + {8'h00, bc};
            default: pdu_len = 16'h0000;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Buffers in both data paths
    // ------------------------------------------------------------
    skid_buffer2 #(.WIDTH(9)) u_rx_buf (
        .ref_clk(ref_clk), .rst_n(rst_n),
        .in_valid(rxb_valid), .in_data(rxb_beat), .in_ready(rxb_ready),
        .out_valid(pdu_valid), .out_data(pdu_beat), .out_ready(pdu_ready)
    );
    skid_buffer2 #(.WIDTH(9)) u_tx_buf (
        .ref_clk(ref_clk), .rst_n(rst_n),
        .in_valid(txb_valid), .in_data(txb_beat), .in_ready(txb_ready),
        .out_valid(tx_valid), .out_data(tx_beat), .out_ready(tx_ready)
    );

    assign rx_take = rx_valid && rxb_ready;
    assign rsp_take = rsp_valid && txb_ready && s_reg.tst == adu_pkg::TX_BODY;
    assign rsp_len_field = rsp_pdu_len + adu_pkg::UID_BYTES;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.pack_err = 1'b0;
        rxb_valid = 1'b0;
        rxb_beat = '{data: rx_data, last: 1'b0};
        txb_valid = 1'b0;
        txb_beat = '{data: rsp_data, last: 1'b0};
        case (s_reg.rst)
            adu_pkg::RX_HDR:
            begin
                if (rx_take)
                begin
                    s_next.ridx = s_reg.ridx + 3'h1;
                    case (s_reg.ridx)
                        adu_pkg::POS_TID_HI: s_next.hdr.tid[15:8] = rx_data;
                        adu_pkg::POS_TID_LO: s_next.hdr.tid[7:0] = rx_data;
                        adu_pkg::POS_PID_HI: s_next.hdr.pid[15:8] = rx_data;
                        adu_pkg::POS_PID_LO: s_next.hdr.pid[7:0] = rx_data;
                        adu_pkg::POS_LEN_HI: s_next.hdr.len[15:8] = rx_data;
                        adu_pkg::POS_LEN_LO: s_next.hdr.len[7:0] = rx_data;
                        default: s_next.hdr.uid = rx_data;
                    endcase
                    if (s_reg.ridx == adu_pkg::POS_UID)
                    begin
                        s_next.ridx = 3'h0;
                        s_next.pos = 16'h0000;
                        s_next.bc = 8'h00;
                        s_next.rem = s_reg.hdr.len - adu_pkg::UID_BYTES;
                        s_next.drop = (s_reg.hdr.pid != adu_pkg::PROTO_ID)
                            || (rx_dst_port != adu_pkg::SERVER_PORT)
                            || (s_reg.hdr.len == 16'h0000);
                        if (s_reg.hdr.len <= adu_pkg::UID_BYTES)
                        begin
                            s_next.done = !s_next.drop;
                            s_next.len_err = !s_next.drop;
                            s_next.pack_err = !rx_seg_end;
                        end
                        else if (s_next.drop)
                            s_next.rst = adu_pkg::RX_SKIP;
                        else
                            s_next.rst = adu_pkg::RX_BODY;
                    end
                end
            end
            adu_pkg::RX_BODY:
            begin
                rxb_valid = rx_valid;
                rxb_beat.last = (s_reg.rem == 16'h0001);
                if (rx_take)
                begin
                    s_next.pos = s_reg.pos + 16'h0001;
                    s_next.rem = s_reg.rem - 16'h0001;
                    if (s_reg.pos == 16'h0000)
                    begin
                        s_next.func = rx_data;
                        s_next.tbl = table_of(rx_data);
                        s_next.wr = is_write(rx_data);
                    end
                    else if (s_reg.pos == bc_pos(s_reg.func))
                        s_next.bc = rx_data;
                    if (s_reg.rem == 16'h0001)
                    begin
                        s_next.rst = adu_pkg::RX_HDR;
                        s_next.done = 1'b1;
                        s_next.len_err = (pdu_len(s_next.func, s_next.bc)
                            != s_reg.hdr.len - adu_pkg::UID_BYTES)
                            && (pdu_len(s_next.func, s_next.bc)
                            != 16'h0000);
                        s_next.pack_err = !rx_seg_end;
                    end
                end
            end
            adu_pkg::RX_SKIP:
                if (rx_take)
                begin
                    s_next.rem = s_reg.rem - 16'h0001;
                    if (s_reg.rem == 16'h0001)
                        s_next.rst = adu_pkg::RX_HDR;
                end
            default: s_next.rst = adu_pkg::RX_HDR;
        endcase
        case (s_reg.tst)
            adu_pkg::TX_IDLE:
                if (rsp_start)
                begin
                    s_next.tst = adu_pkg::TX_HDR;
                    s_next.tidx = 3'h0;
                    s_next.tlen = rsp_len_field;
                    s_next.trem = rsp_pdu_len;
                end
            adu_pkg::TX_HDR:
            begin
                txb_valid = 1'b1;
                case (s_reg.tidx)
                    adu_pkg::POS_TID_HI: txb_beat.data = s_reg.hdr.tid[15:8];
                    adu_pkg::POS_TID_LO: txb_beat.data = s_reg.hdr.tid[7:0];
                    adu_pkg::POS_PID_HI: txb_beat.data = s_reg.hdr.pid[15:8];
                    adu_pkg::POS_PID_LO: txb_beat.data = s_reg.hdr.pid[7:0];
                    adu_pkg::POS_LEN_HI: txb_beat.data = s_reg.tlen[15:8];
                    adu_pkg::POS_LEN_LO: txb_beat.data = s_reg.tlen[7:0];
                    default: txb_beat.data = s_reg.hdr.uid;
                endcase
                txb_beat.last = (s_reg.tidx == adu_pkg::POS_UID)
                    && (s_reg.trem == 16'h0000);
                if (txb_ready)
                begin
                    s_next.tidx = s_reg.tidx + 3'h1;
                    if (s_reg.tidx == adu_pkg::POS_UID)
                        s_next.tst = (s_reg.trem == 16'h0000)
                            ? adu_pkg::TX_IDLE : adu_pkg::TX_BODY;
                end
            end
            adu_pkg::TX_BODY:
            begin
                txb_valid = rsp_valid;
                txb_beat.last = (s_reg.trem == 16'h0001);
                if (rsp_take)
                begin
                    s_next.trem = s_reg.trem - 16'h0001;
                    if (s_reg.trem == 16'h0001)
                        s_next.tst = adu_pkg::TX_IDLE;
                end
            end
            default: s_next.tst = adu_pkg::TX_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            s_reg <= '{rst: adu_pkg::RX_HDR, tbl: adu_pkg::TBL_NONE,
                tst: adu_pkg::TX_IDLE, default: '0};
        else
            s_reg <= s_next;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rx_ready = rxb_ready;
    assign rsp_ready = txb_ready;
    assign rsp_active = (s_reg.tst == adu_pkg::TX_BODY);
    assign req_hdr = s_reg.hdr;
    assign req_func = s_reg.func;
    assign req_table = s_reg.tbl;
    assign req_write = s_reg.wr;
    assign req_done = s_reg.done;
    assign req_len_err = s_reg.len_err;
    assign req_pack_err = s_reg.pack_err;

endmodule

// file: src/skid_buffer2.sv
`timescale 1ns/100ps
module skid_buffer2 #(
    parameter int WIDTH = 9
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Filling side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Draining side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);

    typedef struct packed {
        logic v0;
        logic [WIDTH-1:0] d0;
        logic v1;
        logic [WIDTH-1:0] d1;
        logic rdy;
    } buf_state_t;

    buf_state_t st_reg;
    buf_state_t st_next;

    // ------------------------------------------------------------
    // Two slots, head slot drives the output
    // ------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        if (st_reg.v0 && out_ready)
        begin
            st_next.v0 = st_reg.v1;
            st_next.d0 = st_reg.d1;
            st_next.v1 = 1'b0;
        end
        if (in_valid && st_reg.rdy)
        begin
            if (!st_next.v0)
            begin
                st_next.v0 = 1'b1;
                st_next.d0 = in_data;
            end
            else
            begin
                st_next.v1 = 1'b1;
                st_next.d1 = in_data;
            end
        end
        st_next.rdy = !st_next.v1;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            st_reg <= '{v0: 1'b0, d0: '0, v1: 1'b0, d1: '0, rdy: 1'b1};
        else
            st_reg <= st_next;
    end

    assign in_ready = st_reg.rdy;
    assign out_valid = st_reg.v0;
    assign out_data = st_reg.d0;

endmodule
